// ---- dtio_pkg.sv ----
// shared constants, register map and carrier types for the terminal io block
package dtio_pkg;

  localparam int unsigned CLK_HZ            = 50_000_000;
  localparam int unsigned DELAY_STEP_MS     = 100;
  localparam int unsigned DELAY_STEP_CYCLES = CLK_HZ / 1000 * DELAY_STEP_MS;
  localparam logic [15:0] DELAY_MAX_STEPS   = 16'h8CA0;
  localparam int unsigned PULSE_MAX_HZ      = 100_000;
  localparam logic [31:0] PULSE_MIN_PERIOD  = 32'(CLK_HZ / PULSE_MAX_HZ);

  localparam int unsigned NUM_CFG    = 13;
  localparam int unsigned NUM_REGS   = 17;
  localparam int unsigned NUM_DIN    = 10;
  localparam int unsigned NUM_DELAY  = 3;
  localparam int unsigned NUM_AIN    = 3;
  localparam int unsigned NUM_FOUT   = 5;

  localparam logic [11:0] OFS_BELOW_MIN   = 12'h000;
  localparam logic [11:0] OFS_IN1_DELAY   = 12'h004;
  localparam logic [11:0] OFS_IN2_DELAY   = 12'h008;
  localparam logic [11:0] OFS_IN3_DELAY   = 12'h00C;
  localparam logic [11:0] OFS_POL_LOW     = 12'h010;
  localparam logic [11:0] OFS_POL_HIGH    = 12'h014;
  localparam logic [11:0] OFS_AIN2_TYPE   = 12'h018;
  localparam logic [11:0] OFS_MUX_MODE    = 12'h01C;
  localparam logic [11:0] OFS_SWITCH_FN   = 12'h020;
  localparam logic [11:0] OFS_RELAY1_FN   = 12'h024;
  localparam logic [11:0] OFS_RELAY2_FN   = 12'h028;
  localparam logic [11:0] OFS_OC1_FN      = 12'h02C;
  localparam logic [11:0] OFS_EXP_FN      = 12'h030;
  localparam logic [11:0] OFS_STATUS      = 12'h034;
  localparam logic [11:0] OFS_AIN1_RESULT = 12'h038;
  localparam logic [11:0] OFS_AIN2_RESULT = 12'h03C;
  localparam logic [11:0] OFS_AIN3_RESULT = 12'h040;

  // register indices of the configuration words
  localparam int unsigned IDX_BELOW_MIN = 0;
  localparam int unsigned IDX_IN1_DELAY = 1;
  localparam int unsigned IDX_POL_LOW   = 4;
  localparam int unsigned IDX_POL_HIGH  = 5;
  localparam int unsigned IDX_AIN2_TYPE = 6;
  localparam int unsigned IDX_MUX_MODE  = 7;
  localparam int unsigned IDX_FIRST_FN  = 8;

  localparam logic [15:0] CFG_RESET [NUM_CFG] = '{
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0002, 16'h0000, 16'h0001, 16'h0004};

  localparam logic [3:0] FN_NONE      = 4'h0;
  localparam logic [3:0] FN_RUNNING   = 4'h1;
  localparam logic [3:0] FN_FAULT     = 4'h2;
  localparam logic [3:0] FN_FREQ_LVL  = 4'h3;
  localparam logic [3:0] FN_FREQ_ARR  = 4'h4;
  localparam logic [3:0] FN_ZERO_RUN  = 4'h5;
  localparam logic [3:0] FN_OVL_WARN  = 4'h6;
  localparam logic [3:0] BELOW_USE_MIN  = 4'h0;
  localparam logic [3:0] BELOW_USE_ZERO = 4'h1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic running;
    logic freqIsZero;
    logic faulted;
    logic freqLevelDetectOne;
    logic freqArrived;
    logic overloadPrealarm;
  } dtio_drive_s;

  typedef struct packed {
    logic signed [15:0] level;
    logic signed [15:0] curveMin;
    logic signed [15:0] minSetting;
    logic signed [15:0] curveSetting;
  } dtio_analog_s;

  // one decimal digit of a parameter word, ones digit at position 0
  function automatic logic [3:0] decDigit(input logic [15:0] value, input int unsigned pos);
    logic [15:0] v;
    v = value;
    for (int unsigned i = 0; i < 5; i++) begin
      if (i < pos) begin
        v = v / 16'd10;
      end
    end
    return 4'(v % 16'd10);
  endfunction

endpackage

// ---- dtio_terminal_io.sv ----
// terminal input conditioning and output function routing behind an axi4-lite slave
// What this block does
// - analog digits ones/tens/hundreds select below-minimum handling
// - digit 0: below minimum gives curve minimum setting
// - digit 1: below minimum gives zero percent
// - input change delay 0 to 3600 s, 0.1 s
// - only inputs one to three get delay
// - inputs one-five polarity from first parameter digits
// - inputs six-ten polarity from second parameter digits
// - active high valid when connected, low inverted
// - second analog input voltage at 0, current 1
// - multiplexed terminal pulse at 0, switching at 1
// - pulse output frequency limited to 100 kHz
// - five outputs each route one selectable function
// - function code zero keeps output inactive
// - code 1 asserts while running, zero frequency included
// - code 2 asserts on fault shutdown
// - codes 3 and 4 select level-detect, arrival
// - code 5 asserts only running at zero frequency
// - code 6 asserts on motor overload pre-alarm
//
// Chosen here: register access over AXI4-Lite and the address map.
`timescale 1ns/1ns
`default_nettype none

module dtio_terminal_io #(
  parameter int unsigned DELAY_STEP_CYCLES = dtio_pkg::DELAY_STEP_CYCLES
) (
  input  wire logic                  clock,
  input  wire logic                  srst,
  input  wire logic [11:0]           s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [11:0]           s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [9:0]            digitalInConnected,
  output logic [9:0]                 digitalInValid,
  input  wire dtio_pkg::dtio_analog_s analogInOne,
  input  wire dtio_pkg::dtio_analog_s analogInTwo,
  input  wire dtio_pkg::dtio_analog_s analogInThree,
  output logic signed [15:0]         analogSettingOne,
  output logic signed [15:0]         analogSettingTwo,
  output logic signed [15:0]         analogSettingThree,
  output logic                       analogTwoIsCurrent,
  input  wire dtio_pkg::dtio_drive_s driveStatus,
  input  wire logic [31:0]           pulsePeriodCycles,
  output logic                       multiplexedTerminal,
  output logic                       relayOne,
  output logic                       relayTwo,
  output logic                       openCollectorOutputOne,
  output logic                       expansionOutput
);

  logic [15:0] cfg_ff [dtio_pkg::NUM_CFG];
  logic        awTaken_ff;
  logic        wTaken_ff;
  logic [11:0] awAddr_ff;
  logic [31:0] wData_ff;
  logic [3:0]  wStrb_ff;
  logic        bvalid_ff;
  logic [1:0]  bresp_ff;
  logic        rvalid_ff;
  logic [1:0]  rresp_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [1:0]  nxt_rresp;
  logic [9:0]  wrIndex;
  logic [9:0]  rdIndex;
  logic        doWrite;

  logic [9:0]  syncA_ff;
  logic [9:0]  syncB_ff;
  logic [9:0]  activeLow;
  logic [9:0]  validated;
  logic [9:0]  dinValid_ff;
  logic [31:0] tickCnt_ff;
  logic        tick_ff;

  logic [31:0] pulseCnt_ff;
  logic        pulseLevel_ff;
  logic [31:0] pulsePeriod;

  logic [4:0]  fnOut_ff;
  logic        muxOut_ff;
  logic signed [15:0] aSet_ff [dtio_pkg::NUM_AIN];
  dtio_pkg::dtio_analog_s ain [dtio_pkg::NUM_AIN];

  assign ain[0] = analogInOne;
  assign ain[1] = analogInTwo;
  assign ain[2] = analogInThree;

  // ---------------- axi4-lite slave ----------------
  // address and data are latched separately so either may arrive first
  assign s_axi_awready = !awTaken_ff && !bvalid_ff;
  assign s_axi_wready  = !wTaken_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;
  assign wrIndex       = awAddr_ff[11:2];
  assign rdIndex       = s_axi_araddr[11:2];
  assign doWrite       = awTaken_ff && wTaken_ff;

  always_ff @(posedge clock) begin
    if (srst) begin
      awTaken_ff <= 1'b0;
      awAddr_ff  <= 12'h000;
    end else if (s_axi_awvalid && s_axi_awready) begin
      awTaken_ff <= 1'b1;
      awAddr_ff  <= s_axi_awaddr;
    end else if (doWrite) begin
      awTaken_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wTaken_ff <= 1'b0;
      wData_ff  <= 32'h0000_0000;
      wStrb_ff  <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      wTaken_ff <= 1'b1;
      wData_ff  <= s_axi_wdata;
      wStrb_ff  <= s_axi_wstrb;
    end else if (doWrite) begin
      wTaken_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= dtio_pkg::RESP_OKAY;
    end else if (doWrite) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= (wrIndex < 10'(dtio_pkg::NUM_CFG)) ? dtio_pkg::RESP_OKAY
                                                     : dtio_pkg::RESP_SLVERR;
    end else if (bvalid_ff && s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  // parameter words; the delay words saturate at one hour so the timer never overruns
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < dtio_pkg::NUM_CFG; i++) begin
        cfg_ff[i] <= dtio_pkg::CFG_RESET[i];
      end
    end else if (doWrite && (wrIndex < 10'(dtio_pkg::NUM_CFG))) begin
      for (int i = 0; i < dtio_pkg::NUM_CFG; i++) begin
        if (wrIndex == 10'(i)) begin
          logic [15:0] v;
          v = cfg_ff[i];
          if (wStrb_ff[0]) begin
            v[7:0] = wData_ff[7:0];
          end
          if (wStrb_ff[1]) begin
            v[15:8] = wData_ff[15:8];
          end
          if ((i >= dtio_pkg::IDX_IN1_DELAY)
              && (i < dtio_pkg::IDX_IN1_DELAY + dtio_pkg::NUM_DELAY)
              && (v > dtio_pkg::DELAY_MAX_STEPS)) begin
            v = dtio_pkg::DELAY_MAX_STEPS;
          end
          cfg_ff[i] <= v;
        end
      end
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_rresp = dtio_pkg::RESP_OKAY;
    if (rdIndex < 10'(dtio_pkg::NUM_CFG)) begin
      nxt_rdata = {16'h0000, cfg_ff[rdIndex[3:0]]};
    end else begin
      case ({rdIndex, 2'b00})
        dtio_pkg::OFS_STATUS:
          nxt_rdata = {16'h0000, muxOut_ff, fnOut_ff, dinValid_ff};
        dtio_pkg::OFS_AIN1_RESULT: nxt_rdata = {{16{aSet_ff[0][15]}}, aSet_ff[0]};
        dtio_pkg::OFS_AIN2_RESULT: nxt_rdata = {{16{aSet_ff[1][15]}}, aSet_ff[1]};
        dtio_pkg::OFS_AIN3_RESULT: nxt_rdata = {{16{aSet_ff[2][15]}}, aSet_ff[2]};
        default: nxt_rresp = dtio_pkg::RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= dtio_pkg::RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= nxt_rresp;
      rdata_ff  <= nxt_rdata;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ---------------- analog below-minimum handling ----------------
  // curve scaling happens upstream; this stage only overrides below the curve minimum
  always_ff @(posedge clock) begin
    if (srst) begin
      for (int i = 0; i < dtio_pkg::NUM_AIN; i++) begin
        aSet_ff[i] <= 16'sh0000;
      end
    end else begin
      for (int i = 0; i < dtio_pkg::NUM_AIN; i++) begin
        logic [3:0] choice;
        choice = dtio_pkg::decDigit(cfg_ff[dtio_pkg::IDX_BELOW_MIN], i);
        if (ain[i].level >= ain[i].curveMin) begin
          aSet_ff[i] <= ain[i].curveSetting;
        end else if (choice == dtio_pkg::BELOW_USE_ZERO) begin
          aSet_ff[i] <= 16'sh0000;
        end else begin
          aSet_ff[i] <= ain[i].minSetting;
        end
      end
    end
  end

  assign analogSettingOne   = aSet_ff[0];
  assign analogSettingTwo   = aSet_ff[1];
  assign analogSettingThree = aSet_ff[2];
  // only bit 0 counts; the jumper must match it, which the block cannot check
  assign analogTwoIsCurrent = cfg_ff[dtio_pkg::IDX_AIN2_TYPE][0];

  // ---------------- digital inputs ----------------
  always_ff @(posedge clock) begin
    if (srst) begin
      syncA_ff <= 10'h000;
      syncB_ff <= 10'h000;
    end else begin
      syncA_ff <= digitalInConnected;
      syncB_ff <= syncA_ff;
    end
  end

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      activeLow[i]     = dtio_pkg::decDigit(cfg_ff[dtio_pkg::IDX_POL_LOW], i) == 4'h1;
      activeLow[i + 5] = dtio_pkg::decDigit(cfg_ff[dtio_pkg::IDX_POL_HIGH], i) == 4'h1;
    end
  end

  // polarity first, so the delay below times the validated state both ways
  assign validated = syncB_ff ^ activeLow;

  // 0.1 s time base shared by the three delayed inputs
  always_ff @(posedge clock) begin
    if (srst) begin
      tickCnt_ff <= 32'h0000_0000;
      tick_ff    <= 1'b0;
    end else if (tickCnt_ff >= 32'(DELAY_STEP_CYCLES - 1)) begin
      tickCnt_ff <= 32'h0000_0000;
      tick_ff    <= 1'b1;
    end else begin
      tickCnt_ff <= tickCnt_ff + 32'h0000_0001;
      tick_ff    <= 1'b0;
    end
  end

  // the first step may be short by up to one tick since the time base runs free
  for (genvar g = 0; g < dtio_pkg::NUM_DELAY; g++) begin : gDelay
    logic [15:0] stepCnt_ff;
    always_ff @(posedge clock) begin
      if (srst) begin
        stepCnt_ff     <= 16'h0000;
        dinValid_ff[g] <= 1'b0;
      end else if (validated[g] == dinValid_ff[g]) begin
        stepCnt_ff <= 16'h0000;
      end else if (cfg_ff[dtio_pkg::IDX_IN1_DELAY + g] == 16'h0000) begin
        dinValid_ff[g] <= validated[g];
      end else if (tick_ff) begin
        if (stepCnt_ff + 16'h0001 >= cfg_ff[dtio_pkg::IDX_IN1_DELAY + g]) begin
          dinValid_ff[g] <= validated[g];
          stepCnt_ff     <= 16'h0000;
        end else begin
          stepCnt_ff <= stepCnt_ff + 16'h0001;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      dinValid_ff[9:3] <= 7'h00;
    end else begin
      dinValid_ff[9:3] <= validated[9:3];
    end
  end

  assign digitalInValid = dinValid_ff;

  // ---------------- output function routing ----------------
  function automatic logic routeFn(input logic [15:0] code, input dtio_pkg::dtio_drive_s st);
    logic hit;
    hit = 1'b0;
    if (code[15:4] == 12'h000) begin
      case (code[3:0])
        dtio_pkg::FN_NONE:     hit = 1'b0;
        dtio_pkg::FN_RUNNING:  hit = st.running;
        dtio_pkg::FN_FAULT:    hit = st.faulted;
        dtio_pkg::FN_FREQ_LVL: hit = st.freqLevelDetectOne;
        dtio_pkg::FN_FREQ_ARR: hit = st.freqArrived;
        dtio_pkg::FN_ZERO_RUN: hit = st.running && st.freqIsZero;
        dtio_pkg::FN_OVL_WARN: hit = st.overloadPrealarm;
        default:               hit = 1'b0;
      endcase
    end
    return hit;
  endfunction

  // order: switching output, relay one, relay two, open collector one, expansion
  always_ff @(posedge clock) begin
    if (srst) begin
      fnOut_ff <= 5'h00;
    end else begin
      for (int i = 0; i < dtio_pkg::NUM_FOUT; i++) begin
        fnOut_ff[i] <= routeFn(cfg_ff[dtio_pkg::IDX_FIRST_FN + i], driveStatus);
      end
    end
  end

  assign relayOne               = fnOut_ff[1];
  assign relayTwo               = fnOut_ff[2];
  assign openCollectorOutputOne = fnOut_ff[3];
  assign expansionOutput        = fnOut_ff[4];

  // ---------------- multiplexed terminal ----------------
  // periods shorter than the limit are stretched rather than refused
  assign pulsePeriod = (pulsePeriodCycles < dtio_pkg::PULSE_MIN_PERIOD)
                       ? dtio_pkg::PULSE_MIN_PERIOD : pulsePeriodCycles;

  always_ff @(posedge clock) begin
    if (srst) begin
      pulseCnt_ff   <= 32'h0000_0000;
      pulseLevel_ff <= 1'b0;
    end else if ((pulsePeriodCycles == 32'h0000_0000) || cfg_ff[dtio_pkg::IDX_MUX_MODE][0]) begin
      pulseCnt_ff   <= 32'h0000_0000;
      pulseLevel_ff <= 1'b0;
    end else if (pulseCnt_ff >= (pulsePeriod >> 1) - 32'h0000_0001) begin
      pulseCnt_ff   <= 32'h0000_0000;
      pulseLevel_ff <= !pulseLevel_ff;
    end else begin
      pulseCnt_ff <= pulseCnt_ff + 32'h0000_0001;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      muxOut_ff <= 1'b0;
    end else if (cfg_ff[dtio_pkg::IDX_MUX_MODE][0]) begin
      muxOut_ff <= fnOut_ff[0];
    end else begin
      muxOut_ff <= pulseLevel_ff;
    end
  end

  assign multiplexedTerminal = muxOut_ff;

endmodule

`default_nettype wire

// ---- dtio_io_chk_sva.sv ----
// assertion checker for the terminal io block, bound to its ports
`timescale 1ns/1ns
`default_nettype none

module dtio_io_chk (
  input wire logic                   clock,
  input wire logic                   srst,
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic [1:0]             s_axi_bresp,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_bready,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic [31:0]            s_axi_rdata,
  input wire logic                   s_axi_rvalid,
  input wire logic                   s_axi_rready,
  input wire logic [9:0]             digitalInConnected,
  input wire logic [9:0]             digitalInValid,
  input wire dtio_pkg::dtio_analog_s analogInOne,
  input wire dtio_pkg::dtio_analog_s analogInThree,
  input wire logic signed [15:0]     analogSettingOne,
  input wire logic signed [15:0]     analogSettingThree,
  input wire logic                   multiplexedTerminal,
  input wire logic                   relayOne,
  input wire logic                   relayTwo,
  input wire logic                   openCollectorOutputOne,
  input wire logic                   expansionOutput
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (srst);

  chk_reset_outs_low: assert property (disable iff (1'b0) srst |=> !relayOne && !relayTwo
    && !openCollectorOutputOne && !expansionOutput && !multiplexedTerminal && digitalInValid == '0)
    else $error("outputs not cleared by reset");
  chk_write_resp_late: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  chk_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  chk_read_data_late: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  chk_write_busy_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  chk_read_busy_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  // above the curve minimum the handling digit must not matter
  chk_ain_one_pass: assert property (analogInOne.level >= analogInOne.curveMin |=>
    analogSettingOne == $past(analogInOne.curveSetting)) else $error("input one setting wrong");
  chk_ain_three_pass: assert property (analogInThree.level >= analogInThree.curveMin |=>
    analogSettingThree == $past(analogInThree.curveSetting)) else $error("input three wrong");
  chk_input_sync_gap: assert property ($changed(digitalInConnected) |=>
    $stable(digitalInValid)) else $error("input reached output without synchroniser");
endmodule

bind dtio_terminal_io dtio_io_chk uChk (.clock, .srst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .digitalInConnected,
  .digitalInValid, .analogInOne, .analogInThree, .analogSettingOne, .analogSettingThree,
  .multiplexedTerminal, .relayOne, .relayTwo, .openCollectorOutputOne, .expansionOutput);

`default_nettype wire

// ---- dtio_field_wiring.sv ----
// model of the field wiring: switches to the common return and the analog jumper
`timescale 1ns/1ns
`default_nettype none

module dtio_field_wiring #(
  parameter logic JUMPER_CURRENT = 1'b1
) (
  input  wire logic       clock,
  input  wire logic [9:0] switchClosed,
  output logic [9:0]      digitalInConnected,
  output logic            jumperIsCurrent
);
  initial digitalInConnected = '0;
  // contacts settle mid-cycle, unrelated to the edge, so a synchroniser is needed
  always @(posedge clock) begin
    #7 digitalInConnected = switchClosed;
  end
  // installer sets the jumper; software must match it
  assign jumperIsCurrent = JUMPER_CURRENT;
endmodule

`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the terminal io block
`timescale 1ns/1ns
`default_nettype none

module testbench;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [11:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, awready, wvalid = 1'b0, wready, bvalid, bready = 1'b0;
  logic arvalid = 1'b0, arready, rvalid, rready = 1'b0;
  logic [31:0] wdata = '0, rdata, pulsePeriod = '0, d;
  logic [1:0] bresp, rresp, r;
  logic [9:0] switchClosed = 10'h3FF, conn, valid;
  dtio_pkg::dtio_analog_s ain1 = '0, ain2 = '0, ain3 = '0;
  logic signed [15:0] set1, set2, set3;
  logic isCurrent, jumper, mt, r1, r2, oc1, ex, p;
  dtio_pkg::dtio_drive_s status = '0;
  int mismatches = 0, comparisons = 0, n;
  // function code, status, expected output
  localparam logic [10:0] ROWS [16] = '{{4'h0, 6'h3F, 1'b0}, {4'h1, 6'h20, 1'b1},
    {4'h1, 6'h30, 1'b1}, {4'h1, 6'h1F, 1'b0}, {4'h2, 6'h08, 1'b1}, {4'h2, 6'h37, 1'b0},
    {4'h3, 6'h04, 1'b1}, {4'h3, 6'h3B, 1'b0}, {4'h4, 6'h02, 1'b1}, {4'h4, 6'h3D, 1'b0},
    {4'h5, 6'h30, 1'b1}, {4'h5, 6'h10, 1'b0}, {4'h5, 6'h20, 1'b0}, {4'h6, 6'h01, 1'b1},
    {4'h6, 6'h3E, 1'b0}, {4'h7, 6'h3F, 1'b0}};

  always #10 clock = ~clock;

  dtio_field_wiring uWire (.clock(clock), .switchClosed(switchClosed),
    .digitalInConnected(conn), .jumperIsCurrent(jumper));

  dtio_terminal_io #(.DELAY_STEP_CYCLES(20)) DUT (.clock(clock), .srst(srst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .digitalInConnected(conn), .digitalInValid(valid), .analogInOne(ain1),
    .analogInTwo(ain2), .analogInThree(ain3), .analogSettingOne(set1),
    .analogSettingTwo(set2), .analogSettingThree(set3), .analogTwoIsCurrent(isCurrent),
    .driveStatus(status), .pulsePeriodCycles(pulsePeriod), .multiplexedTerminal(mt),
    .relayOne(r1), .relayTwo(r2), .openCollectorOutputOne(oc1), .expansionOutput(ex));

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // channels are released independently as each is taken
  // ready follows the answer by one cycle, so the slave's hold under a stall is exercised
  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    @(posedge clock);
    awaddr <= a;
    wdata <= {16'h0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid && !bready) bready <= 1'b1;
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      if (rvalid && !rready) rready <= 1'b1;
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    mismatches++;
    print_verdict();
  end

  initial begin
    ain1 <= {16'sd10, 16'sd0, 16'sd77, 16'sd900};
    ain3 <= {16'sd10, 16'sd0, 16'sd55, 16'sd700};
    repeat (8) @(posedge clock);
    srst <= 1'b0;
    for (int i = 0; i < 13; i++) begin
      rd(12'(4 * i));
      cmpWord(d, {16'h0000, dtio_pkg::CFG_RESET[i]});
    end
    rd(12'h044);
    cmpWord(32'(r), 32'(dtio_pkg::RESP_SLVERR));
    wr(12'h034, 16'h0001);
    cmpWord(32'(r), 32'(dtio_pkg::RESP_SLVERR));
    foreach (ROWS[i]) begin
      wr(dtio_pkg::OFS_RELAY2_FN, {12'h000, ROWS[i][10:7]});
      status <= dtio_pkg::dtio_drive_s'(ROWS[i][6:1]);
      repeat (3) @(posedge clock);
      cmpWord(32'(r2), 32'(ROWS[i][0]));
    end
    // one faulted source routed to each output in turn
    wr(dtio_pkg::OFS_MUX_MODE, 16'h0001);
    status <= 6'h08;
    for (int i = 0; i < 5; i++) begin
      for (int j = 0; j < 5; j++) wr(12'(12'h020 + 4 * j), (i == j) ? 16'h0002 : 16'h0000);
      repeat (3) @(posedge clock);
      cmpWord(32'({mt, r1, r2, oc1, ex}), 32'(5'h10 >> i));
    end
    // pulse request of 100 cycles must stretch to the 100 kHz limit
    wr(dtio_pkg::OFS_MUX_MODE, 16'h0000);
    pulsePeriod <= 32'd100;
    p = mt;
    while (mt === p) @(posedge clock);
    n = 0;
    p = mt;
    while (mt === p) begin
      @(posedge clock);
      n++;
    end
    cmpWord(32'(n), 32'd250);
    pulsePeriod <= 32'd0;
    wr(dtio_pkg::OFS_POL_LOW, 16'h2775);
    wr(dtio_pkg::OFS_POL_HIGH, 16'h000B);
    repeat (6) @(posedge clock);
    cmpWord(32'(valid), 32'h38A);
    wr(dtio_pkg::OFS_POL_LOW, 16'h0000);
    wr(dtio_pkg::OFS_POL_HIGH, 16'h0000);
    wr(dtio_pkg::OFS_IN1_DELAY, 16'h0003);
    repeat (6) @(posedge clock);
    for (int k = 0; k < 2; k++) begin
      switchClosed <= (k == 0) ? 10'h3F6 : 10'h3FF;
      repeat (10) @(posedge clock);
      cmpWord(32'({valid[3], valid[0]}), (k == 0) ? 32'd1 : 32'd2);
      repeat (60) @(posedge clock);
      cmpWord(32'({valid[3], valid[0]}), (k == 0) ? 32'd0 : 32'd3);
    end
    wr(dtio_pkg::OFS_IN1_DELAY, 16'hFFFF);
    rd(dtio_pkg::OFS_IN1_DELAY);
    cmpWord(d, 32'h00008CA0);
    wr(dtio_pkg::OFS_AIN2_TYPE, {15'h0000, jumper});
    repeat (2) @(posedge clock);
    cmpWord(32'(isCurrent), 32'(jumper));
    ain2 <= {-16'sd5, 16'sd0, 16'sd66, 16'sd800};
    ain1 <= {-16'sd5, 16'sd0, 16'sd77, 16'sd900};
    ain3 <= {-16'sd5, 16'sd0, 16'sd55, 16'sd700};
    wr(dtio_pkg::OFS_BELOW_MIN, 16'd110);
    repeat (3) @(posedge clock);
    cmpWord(32'({set1, set2}), {16'sd77, 16'sd0});
    cmpWord(32'(set3), 32'd0);
    wr(dtio_pkg::OFS_BELOW_MIN, 16'd1);
    repeat (3) @(posedge clock);
    cmpWord(32'({set1, set2}), {16'sd0, 16'sd66});
    cmpWord(32'(set3), 32'd55);
    rd(dtio_pkg::OFS_AIN3_RESULT);
    cmpWord(d, 32'h0000_0037);
    rd(dtio_pkg::OFS_STATUS);
    cmpWord(d, 32'h0000_43FF);
    // mid-run reset: registers return to their reset values and relay one follows its reset fault function
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    rd(dtio_pkg::OFS_RELAY1_FN);
    cmpWord(d, 32'h0000_0002);
    cmpWord(32'({mt, r1, r2, oc1, ex}), 32'h0000_0008);
    print_verdict();
  end
endmodule

`default_nettype wire
